// [rtl/pwmt_cfg.svh]
// Purpose: offsets, reset values and field positions of the eight-channel pwm timer
// Assumes: word-aligned register port, 8-bit byte offsets
// Notes: included by the top module and by the testbench
`ifndef PWMT_CFG_SVH
`define PWMT_CFG_SVH

// ****************************************
// register offsets
// ****************************************
`define PWMT_OFS_ENABLE 8'h00
`define PWMT_OFS_JOIN 8'h04
`define PWMT_OFS_POLARITY 8'h08
`define PWMT_OFS_ALIGN 8'h0C
`define PWMT_OFS_PCM 8'h10
`define PWMT_OFS_PRESCALE 8'h14
`define PWMT_OFS_STATUS 8'h18
// per-channel groups: address bits [7:5] select, [4:2] give the channel
`define PWMT_GRP_PERIOD 3'h1
`define PWMT_GRP_DUTY 3'h2
`define PWMT_GRP_COUNT 3'h3

// ****************************************
// reset values
// ****************************************
`define PWMT_RST_ENABLE 8'h00
`define PWMT_RST_JOIN 4'h0
`define PWMT_RST_POLARITY 8'hFF
`define PWMT_RST_ALIGN 8'h00
`define PWMT_RST_PCM 1'b0
`define PWMT_RST_PRESCALE 8'h00
`define PWMT_RST_PERIOD 8'hFF
`define PWMT_RST_DUTY 8'h00

// ****************************************
// field positions
// ****************************************
`define PWMT_PCM_BIT 0
`define PWMT_JOIN_MSB 3

`endif

// [rtl/pwmt_pkg.sv]
// Purpose: shared types and the waveform decision of the pwm timer
// Assumes: 16-bit words; no constants from pwmt_cfg.svh are used
// Notes: none
package pwmt_pkg;

	typedef logic [15:0] pwmt_word_t;
	typedef enum logic [1:0] {MODE_LEFT = 2'b00, MODE_CENTRE = 2'b01, MODE_PCM = 2'b10} pwmt_mode_t;
	typedef enum logic {DIR_DOWN = 1'b0, DIR_UP = 1'b1} pwmt_dir_t;

	// zero duty is never active; duty at or above period is always active
	function automatic logic actOf(pwmt_mode_t mode, pwmt_word_t cnt, pwmt_word_t per, pwmt_word_t duty,
		logic carry);
		logic full;
		full = (duty != 16'h0000) && (duty >= per);
		unique case (mode)
			MODE_LEFT: actOf = full || (cnt < duty);
			MODE_CENTRE: actOf = full || ((duty != 16'h0000) && (cnt >= per - duty));
			MODE_PCM: actOf = full || ((duty != 16'h0000) && carry);
			default: actOf = 1'b0;
		endcase
	endfunction

endpackage

// [rtl/pwmt_prescale.sv]
// Purpose: divides the system clock into a one-cycle count enable
// Assumes: divide value is static during normal use
// Notes: a value of n gives one pulse every n+1 cycles
module pwmt_prescale (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [7:0] divide,
	output logic tick
);

	logic [7:0] div_r;
	wire atEnd = (div_r >= divide);

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			div_r <= 8'h00;
			tick <= 1'b0;
		end else begin
			div_r <= atEnd ? 8'h00 : div_r + 8'h01;
			tick <= atEnd;
		end
	end

endmodule // pwmt_prescale

// [rtl/pwmt_pair.sv]
// Purpose: two channel engines that run apart or as one 16-bit channel
// Assumes: staged period and duty come straight from software registers
// Notes: when joined the low engine is held idle and the high engine drives
module pwmt_pair (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic tick,
	input wire logic pairJoin,
	input wire logic [1:0] enable,
	input pwmt_pkg::pwmt_mode_t [1:0] mode,
	input wire logic [1:0][7:0] perStage,
	input wire logic [1:0][7:0] dutyStage,
	output pwmt_pkg::pwmt_word_t [1:0] cnt,
	output pwmt_pkg::pwmt_word_t [1:0] curPer,
	output pwmt_pkg::pwmt_word_t [1:0] curDuty,
	output logic [1:0] bound,
	output logic [1:0] act
);
	import pwmt_pkg::*;

	// high byte from the odd channel, low byte from the even one
	wire pwmt_word_t perJoined = {perStage[1], perStage[0]};
	wire pwmt_word_t dutyJoined = {dutyStage[1], dutyStage[0]};
	wire pwmt_word_t perNext [2];
	wire pwmt_word_t dutyNext [2];
	assign perNext[0] = {8'h00, perStage[0]};
	assign dutyNext[0] = {8'h00, dutyStage[0]};
	assign perNext[1] = pairJoin ? perJoined : {8'h00, perStage[1]};
	assign dutyNext[1] = pairJoin ? dutyJoined : {8'h00, dutyStage[1]};

	for (genvar k = 0; k < 2; k++) begin : g_eng
		pwmt_word_t cnt_r, cnt_nxt, per_r, duty_r, acc_r, acc_nxt;
		pwmt_dir_t dir_r, dir_nxt;
		logic act_r;
		wire [16:0] sum = {1'b0, acc_r} + {1'b0, duty_r};
		wire carry = (sum >= {1'b0, per_r});
		wire last = (per_r == 16'h0000) || (cnt_r == per_r - 16'h0001);
		wire atBound = (mode[k] == MODE_CENTRE) ? (dir_r == DIR_DOWN && cnt_r == 16'h0000) : last;
		// shadows reload at a period edge, or on every cycle while disabled, so a pulse is never cut short
		wire load = !enable[k] || (tick && atBound);

		always_comb begin
			cnt_nxt = cnt_r;
			dir_nxt = dir_r;
			acc_nxt = acc_r;
			if (tick) begin
				unique case (mode[k])
					MODE_CENTRE: begin
						if (dir_r == DIR_UP) begin
							if (last)
								dir_nxt = DIR_DOWN;
							else
								cnt_nxt = cnt_r + 16'h0001;
						end else begin
							if (cnt_r == 16'h0000)
								dir_nxt = DIR_UP;
							else
								cnt_nxt = cnt_r - 16'h0001;
						end
					end
					MODE_LEFT, MODE_PCM: begin
						cnt_nxt = last ? 16'h0000 : cnt_r + 16'h0001;
						// spreads the active ticks over the period instead of one block
						if (mode[k] == MODE_PCM)
							acc_nxt = carry ? 16'(sum - {1'b0, per_r}) : sum[15:0];
					end
					default: cnt_nxt = 16'h0000;
				endcase
			end
			if (!enable[k]) begin
				cnt_nxt = 16'h0000;
				dir_nxt = DIR_UP;
				acc_nxt = 16'h0000;
			end
		end

		always_ff @(posedge clk_sys or posedge reset) begin
			if (reset) begin
				cnt_r <= 16'h0000;
				dir_r <= DIR_UP;
				acc_r <= 16'h0000;
				per_r <= 16'h0000;
				duty_r <= 16'h0000;
				act_r <= 1'b0;
			end else begin
				cnt_r <= cnt_nxt;
				dir_r <= dir_nxt;
				acc_r <= acc_nxt;
				per_r <= load ? perNext[k] : per_r;
				duty_r <= load ? dutyNext[k] : duty_r;
				act_r <= enable[k] && actOf(mode[k], cnt_r, per_r, duty_r, carry);
			end
		end

		assign cnt[k] = cnt_r;
		assign curPer[k] = per_r;
		assign curDuty[k] = duty_r;
		assign bound[k] = atBound;
		assign act[k] = act_r;
	end

endmodule // pwmt_pair

// [rtl/pwmt_timer.sv]
// Purpose: eight-channel pwm timer with joinable pairs, polarity, alignment and pcm mode
// Assumes: single clk_sys at 40 MHz, asynchronous active-high reset, plain register port
// Notes: read data appear one cycle after the read strobe; unmapped reads give zero
// Behaviour
// - eight outputs, each from an 8-bit channel with its own counter, period and duty.
// - each channel repeats its waveform on its own once programmed.
// - duty spans from never active up to active for the whole period.
// - a per-channel polarity bit picks whether active is driven high or low.
// - each channel is left aligned or centred symmetrically in its period.
// - pairs 7/6, 5/4, 3/2 and 1/0 can each join into one 16-bit channel.
// - joining is chosen per pair, so any mix from eight 8-bit to four 16-bit is possible.
// - a pcm mode can replace plain pulse-width output for better signal quality.
//
// The register addresses and strobed register access are this design's own decisions.
`include "pwmt_cfg.svh"

module pwmt_timer (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRdData,
	output logic [7:0] pwmOut
);
	import pwmt_pkg::*;

	// ****************************************
	// register decode
	// ****************************************
	function automatic logic hitOf(logic [7:0] addr, logic [7:0] ofs);
		hitOf = (addr == ofs);
	endfunction

	logic [7:0] enable_r, polarity_r, align_r, prescale_r;
	logic [3:0] join_r;
	logic pcm_r;
	logic [7:0][7:0] period_r, duty_r;
	logic [31:0] rdData_r;
	logic [7:0] pwmOut_r;

	wire [2:0] chanIdx = regAddr[4:2];
	wire aligned = (regAddr[1:0] == 2'b00);
	wire hitPeriod = aligned && (regAddr[7:5] == `PWMT_GRP_PERIOD);
	wire hitDuty = aligned && (regAddr[7:5] == `PWMT_GRP_DUTY);
	wire hitCount = aligned && (regAddr[7:5] == `PWMT_GRP_COUNT);
	wire wrEnable = regWr && hitOf(regAddr, `PWMT_OFS_ENABLE);
	wire wrJoin = regWr && hitOf(regAddr, `PWMT_OFS_JOIN);
	wire wrPolarity = regWr && hitOf(regAddr, `PWMT_OFS_POLARITY);
	wire wrAlign = regWr && hitOf(regAddr, `PWMT_OFS_ALIGN);
	wire wrPcm = regWr && hitOf(regAddr, `PWMT_OFS_PCM);
	wire wrPrescale = regWr && hitOf(regAddr, `PWMT_OFS_PRESCALE);

	// ****************************************
	// channel engines
	// ****************************************
	logic tick;
	pwmt_word_t [7:0] cnt, curPer, curDuty;
	logic [7:0] bound, act, chanEn;
	pwmt_mode_t [7:0] chanMode;

	pwmt_prescale u_prescale (
		.clk_sys(clk_sys),
		.reset(reset),
		.divide(prescale_r),
		.tick(tick)
	);

	for (genvar i = 0; i < 8; i++) begin : g_chan
		// the even channel of a joined pair stands idle at its inactive level
		assign chanEn[i] = enable_r[i] && !((i % 2 == 0) && join_r[i / 2]);
		assign chanMode[i] = pcm_r ? MODE_PCM : (align_r[i] ? MODE_CENTRE : MODE_LEFT);
	end

	for (genvar p = 0; p < 4; p++) begin : g_pair
		// each pair joins on its own bit only
		pwmt_pair u_pair (
			.clk_sys(clk_sys),
			.reset(reset),
			.tick(tick),
			.pairJoin(join_r[p]),
			.enable(chanEn[2 * p +: 2]),
			.mode(chanMode[2 * p +: 2]),
			.perStage(period_r[2 * p +: 2]),
			.dutyStage(duty_r[2 * p +: 2]),
			.cnt(cnt[2 * p +: 2]),
			.curPer(curPer[2 * p +: 2]),
			.curDuty(curDuty[2 * p +: 2]),
			.bound(bound[2 * p +: 2]),
			.act(act[2 * p +: 2])
		);
	end

	// ****************************************
	// software registers
	// ****************************************
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			enable_r <= `PWMT_RST_ENABLE;
			join_r <= `PWMT_RST_JOIN;
			polarity_r <= `PWMT_RST_POLARITY;
			align_r <= `PWMT_RST_ALIGN;
			pcm_r <= `PWMT_RST_PCM;
			prescale_r <= `PWMT_RST_PRESCALE;
		end else begin
			if (wrEnable)
				enable_r <= regWrData[7:0];
			if (wrJoin)
				join_r <= regWrData[`PWMT_JOIN_MSB:0];
			if (wrPolarity)
				polarity_r <= regWrData[7:0];
			if (wrAlign)
				align_r <= regWrData[7:0];
			if (wrPcm)
				pcm_r <= regWrData[`PWMT_PCM_BIT];
			if (wrPrescale)
				prescale_r <= regWrData[7:0];
		end
	end

	// staged values only; engines pick them up at their own boundary
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			period_r <= {8{`PWMT_RST_PERIOD}};
			duty_r <= {8{`PWMT_RST_DUTY}};
		end else begin
			if (regWr && hitPeriod)
				period_r[chanIdx] <= regWrData[7:0];
			if (regWr && hitDuty)
				duty_r[chanIdx] <= regWrData[7:0];
		end
	end

	// ****************************************
	// read path and outputs
	// ****************************************
	logic [31:0] rdMux;
	always_comb begin
		rdMux = 32'h0000_0000;
		if (hitPeriod)
			rdMux = {24'h00_0000, period_r[chanIdx]};
		else if (hitDuty)
			rdMux = {24'h00_0000, duty_r[chanIdx]};
		else if (hitCount)
			rdMux = {16'h0000, cnt[chanIdx]};
		else if (hitOf(regAddr, `PWMT_OFS_ENABLE))
			rdMux = {24'h00_0000, enable_r};
		else if (hitOf(regAddr, `PWMT_OFS_JOIN))
			rdMux = {28'h000_0000, join_r};
		else if (hitOf(regAddr, `PWMT_OFS_POLARITY))
			rdMux = {24'h00_0000, polarity_r};
		else if (hitOf(regAddr, `PWMT_OFS_ALIGN))
			rdMux = {24'h00_0000, align_r};
		else if (hitOf(regAddr, `PWMT_OFS_PCM))
			rdMux = {31'h0000_0000, pcm_r};
		else if (hitOf(regAddr, `PWMT_OFS_PRESCALE))
			rdMux = {24'h00_0000, prescale_r};
		else if (hitOf(regAddr, `PWMT_OFS_STATUS))
			rdMux = {16'h0000, act, pwmOut_r};
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			rdData_r <= 32'h0000_0000;
			pwmOut_r <= ~`PWMT_RST_POLARITY;
		end else begin
			rdData_r <= regRd ? rdMux : 32'h0000_0000;
			pwmOut_r <= ~(act ^ polarity_r);
		end
	end

	assign regRdData = rdData_r;
	assign pwmOut = pwmOut_r;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (reset);

	for (genvar i = 0; i < 8; i++) begin : g_chk
		property p_cntInRange;
			chanEn[i] && curPer[i] != 16'h0000 |-> cnt[i] < curPer[i];
		endproperty
		a_cntInRange: assert property (p_cntInRange) else $error("counter beyond period");

		property p_leftWrap;
			tick && chanEn[i] && chanMode[i] != MODE_CENTRE && curPer[i] != 16'h0000
				&& cnt[i] == curPer[i] - 16'h0001 |=> cnt[i] == 16'h0000;
		endproperty
		a_leftWrap: assert property (p_leftWrap) else $error("counter did not restart period");

		property p_zeroDuty;
			curDuty[i] == 16'h0000 |=> !act[i];
		endproperty
		a_zeroDuty: assert property (p_zeroDuty) else $error("active with zero duty");

		property p_fullDuty;
			chanEn[i] && curDuty[i] != 16'h0000 && curDuty[i] >= curPer[i] |=> act[i];
		endproperty
		a_fullDuty: assert property (p_fullDuty) else $error("full duty not active");

		property p_polarity;
			##1 pwmOut_r[i] == ($past(polarity_r[i]) ~^ $past(act[i]));
		endproperty
		a_polarity: assert property (p_polarity) else $error("output polarity wrong");

		property p_leftShape;
			chanEn[i] && chanMode[i] == MODE_LEFT && curDuty[i] < curPer[i]
				|=> act[i] == ($past(cnt[i]) < $past(curDuty[i]));
		endproperty
		a_leftShape: assert property (p_leftShape) else $error("left aligned pulse wrong");

		property p_centreShape;
			chanEn[i] && chanMode[i] == MODE_CENTRE && curDuty[i] != 16'h0000 && curDuty[i] < curPer[i]
				|=> act[i] == ($past(cnt[i]) >= $past(curPer[i]) - $past(curDuty[i]));
		endproperty
		a_centreShape: assert property (p_centreShape) else $error("centred pulse wrong");

		property p_pcmEmpty;
			chanEn[i] && chanMode[i] == MODE_PCM && curDuty[i] == 16'h0000 ##1 chanEn[i] [*3] |-> !act[i];
		endproperty
		a_pcmEmpty: assert property (p_pcmEmpty) else $error("pcm active at zero density");

		property p_holdMid;
			chanEn[i] && !(tick && bound[i]) |=> $stable(curPer[i]) && $stable(curDuty[i]);
		endproperty
		a_holdMid: assert property (p_holdMid) else $error("settings changed mid period");

		property p_offIdle;
			!chanEn[i] |=> !act[i];
		endproperty
		a_offIdle: assert property (p_offIdle) else $error("disabled channel active");
	end

	for (genvar p = 0; p < 4; p++) begin : g_chkPair
		property p_joinLoad;
			join_r[p] && chanEn[2 * p + 1] && tick && bound[2 * p + 1]
				|=> curPer[2 * p + 1] == {$past(period_r[2 * p + 1]), $past(period_r[2 * p])}
				&& curDuty[2 * p + 1] == {$past(duty_r[2 * p + 1]), $past(duty_r[2 * p])};
		endproperty
		a_joinLoad: assert property (p_joinLoad) else $error("joined value not assembled");

		property p_joinIdle;
			join_r[p] |=> !act[2 * p];
		endproperty
		a_joinIdle: assert property (p_joinIdle) else $error("even channel active while joined");

		property p_splitLoad;
			!join_r[p] && chanEn[2 * p] && tick && bound[2 * p]
				|=> curPer[2 * p] == {8'h00, $past(period_r[2 * p])};
		endproperty
		a_splitLoad: assert property (p_splitLoad) else $error("split channel not 8-bit");
	end

	c_joined: cover property (join_r[0] && chanEn[1] && act[1] ##1 !act[1]);
	c_centre: cover property (chanEn[2] && chanMode[2] == MODE_CENTRE && tick && bound[2]);
	c_pcm: cover property (chanEn[3] && chanMode[3] == MODE_PCM && act[3] ##1 !act[3]);
	c_mixed: cover property (join_r == 4'h5 && chanEn[1] && chanEn[2]);
	c_pcmFull: cover property (chanEn[5] && chanMode[5] == MODE_PCM && curDuty[5] >= curPer[5] && act[5]);

	// ****************************************
	// register port and prescaler checks
	// ****************************************
	property p_rdIdle;
		!regRd |=> regRdData == 32'h0000_0000;
	endproperty
	a_rdIdle: assert property (p_rdIdle) else $error("read data outside read cycle");

	property p_rdNarrow;
		regRd && (hitPeriod || hitDuty) |=> regRdData[31:8] == 24'h00_0000;
	endproperty
	a_rdNarrow: assert property (p_rdNarrow) else $error("upper read bits set");

	property p_wrEnable;
		wrEnable |=> enable_r == $past(regWrData[7:0]);
	endproperty
	a_wrEnable: assert property (p_wrEnable) else $error("enable write lost");

	property p_wrPolarity;
		wrPolarity |=> polarity_r == $past(regWrData[7:0]);
	endproperty
	a_wrPolarity: assert property (p_wrPolarity) else $error("polarity write lost");

	property p_wrAlign;
		wrAlign |=> align_r == $past(regWrData[7:0]);
	endproperty
	a_wrAlign: assert property (p_wrAlign) else $error("alignment write lost");

	property p_wrJoin;
		wrJoin |=> join_r == $past(regWrData[`PWMT_JOIN_MSB:0]);
	endproperty
	a_wrJoin: assert property (p_wrJoin) else $error("join write lost");

	property p_pcmAll;
		pcm_r |-> chanMode == {8{MODE_PCM}};
	endproperty
	a_pcmAll: assert property (p_pcmAll) else $error("pcm not applied to every channel");

	// a zero divide must step the counters on every cycle
	property p_tickEvery;
		prescale_r == 8'h00 |=> tick;
	endproperty
	a_tickEvery: assert property (p_tickEvery) else $error("tick missing at full rate");

	property p_tickSingle;
		tick && prescale_r != 8'h00 |=> !tick;
	endproperty
	a_tickSingle: assert property (p_tickSingle) else $error("tick longer than one cycle");

endmodule // pwmt_timer

// [tb/pwmt_timer_tb.sv]
// Purpose: self-checking bench for the eight-channel pwm timer
// Assumes: prescale 0, so the counters step every clk_sys cycle
// Notes: duty is judged over a window that spans whole periods of every channel, so phase does not matter
module pwmt_timer_tb;
	timeunit 1ns;
	timeprecision 1ps;
`include "pwmt_cfg.svh"

	// window must be a multiple of twice every period used: 2..12 and 480
	localparam int W = 1920;
	localparam int PER_TBL[8] = '{2, 3, 4, 5, 6, 8, 10, 12};

	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic [7:0] regAddr = 8'h00;
	logic [31:0] regWrData = 32'h0000_0000;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic [31:0] regRdData;
	logic [7:0] pwmOut;

	int n_mismatch = 0;
	int check_count = 0;
	logic [31:0] seed = 32'h0000_488E;
	logic [31:0] rdVal;
	logic [7:0] pol;
	logic [7:0] algn;
	logic [3:0] jn;
	logic pcm;
	int per[8];
	int duty[8];
	int actCnt[8];
	int run[8];
	int maxRun[8];

	always #12.5 clk_sys = ~clk_sys;

	pwmt_timer dut_u (
		.clk_sys(clk_sys),
		.reset(reset),
		.regAddr(regAddr),
		.regWrData(regWrData),
		.regWr(regWr),
		.regRd(regRd),
		.regRdData(regRdData),
		.pwmOut(pwmOut)
	);

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic logic [7:0] chA(logic [2:0] grp, int i);
		return {grp, 3'(i), 2'b00};
	endfunction

	// active cycles in the window: d of every p ticks in all three modes
	function automatic int expAct(int p, int d);
		if (d == 0) return 0;
		if (d >= p) return W;
		return W * d / p;
	endfunction

	// longest active run: one pulse of d ticks, or 2d when centred; -1 skips the check
	function automatic int expRun(int p, int d, logic centre, logic pcmOn);
		if (d == 0) return 0;
		if (d >= p) return W;
		if (pcmOn) return -1;
		return centre ? 2 * d : d;
	endfunction

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge clk_sys);
		regWr <= 1'b0;
	endtask

	// data stand only in the cycle after the read edge
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk_sys);
		regRd <= 1'b0;
		#1;
		d = regRdData;
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// ****************************************
	// watchdog
	// ****************************************
	initial begin
		repeat (60000) @(posedge clk_sys);
		n_mismatch++;
		$display("unexpected timeout expected done seen running");
		test_done();
	end

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		int p;
		int d;
		int e;
		repeat (16) @(posedge clk_sys);
		reset <= 1'b0;
		chk("pwmOut after reset", {24'h0, pwmOut}, 32'h0000_0000);
		rd(`PWMT_OFS_ENABLE, rdVal);
		chk("enable reset", rdVal, 32'h0000_0000);
		rd(`PWMT_OFS_JOIN, rdVal);
		chk("join reset", rdVal, 32'h0000_0000);
		rd(`PWMT_OFS_POLARITY, rdVal);
		chk("polarity reset", rdVal, 32'h0000_00FF);
		rd(`PWMT_OFS_ALIGN, rdVal);
		chk("align reset", rdVal, 32'h0000_0000);
		rd(`PWMT_OFS_PCM, rdVal);
		chk("pcm reset", rdVal, 32'h0000_0000);
		for (int i = 0; i < 8; i++) begin
			rd(chA(`PWMT_GRP_PERIOD, i), rdVal);
			chk("period reset", rdVal, 32'h0000_00FF);
			rd(chA(`PWMT_GRP_DUTY, i), rdVal);
			chk("duty reset", rdVal, 32'h0000_0000);
		end
		wr(8'h1C, 32'h0000_00A5);
		rd(8'h1C, rdVal);
		chk("unmapped read", rdVal, 32'h0000_0000);
		rd(8'h21, rdVal);
		chk("unaligned read", rdVal, 32'h0000_0000);
		$display("reset and map test done");
		wr(`PWMT_OFS_PRESCALE, 32'h0000_0000);
		for (int r = 0; r < 6; r++) begin
			jn = (r == 0) ? 4'h0 : (r == 1) ? 4'hF : rnd() & 32'hF;
			pcm = (r >= 4);
			pol = rnd() & 32'hFF;
			algn = rnd() & 32'hFF;
			for (int q = 0; q < 4; q++) begin
				// joined pairs get matching settings on both halves so either half may steer the mode
				if (jn[q]) begin
					pol[2 * q + 1] = pol[2 * q];
					algn[2 * q + 1] = algn[2 * q];
					d = rnd() % 482;
					per[2 * q] = 8'hE0;
					per[2 * q + 1] = 8'h01;
					duty[2 * q] = d & 8'hFF;
					duty[2 * q + 1] = d >> 8;
				end else begin
					for (int k = 0; k < 2; k++) begin
						per[2 * q + k] = PER_TBL[rnd() % 8];
						duty[2 * q + k] = rnd() % (per[2 * q + k] + 2);
					end
				end
			end
			wr(`PWMT_OFS_ENABLE, 32'h0000_0000);
			wr(`PWMT_OFS_JOIN, {28'h0, jn});
			wr(`PWMT_OFS_POLARITY, {24'h0, pol});
			wr(`PWMT_OFS_ALIGN, {24'h0, algn});
			wr(`PWMT_OFS_PCM, {31'h0, pcm});
			for (int i = 0; i < 8; i++) begin
				wr(chA(`PWMT_GRP_PERIOD, i), 32'(per[i]));
				wr(chA(`PWMT_GRP_DUTY, i), 32'(duty[i]));
			end
			rd(chA(`PWMT_GRP_DUTY, 7), rdVal);
			chk("duty readback", rdVal, 32'(duty[7]));
			wr(`PWMT_OFS_ENABLE, 32'h0000_00FF);
			// let every channel pass a period boundary before judging the waveform
			repeat (W) @(posedge clk_sys);
			for (int i = 0; i < 8; i++) begin
				actCnt[i] = 0;
				run[i] = 0;
				maxRun[i] = 0;
			end
			repeat (W) begin
				@(posedge clk_sys);
				#1;
				for (int i = 0; i < 8; i++) begin
					if (pwmOut[i] === pol[i]) begin
						actCnt[i]++;
						run[i]++;
						if (run[i] > maxRun[i]) maxRun[i] = run[i];
					end else begin
						run[i] = 0;
					end
				end
			end
			for (int i = 0; i < 8; i++) begin
				p = per[i];
				d = duty[i];
				if (jn[i / 2]) begin
					p = (i % 2) ? per[i] * 256 + per[i - 1] : 1;
					d = (i % 2) ? duty[i] * 256 + duty[i - 1] : 0;
				end
				chk("active cycles", 32'(actCnt[i]), 32'(expAct(p, d)));
				e = expRun(p, d, algn[i], pcm);
				if (e >= 0) chk("pulse length", 32'(maxRun[i]), 32'(e));
			end
			if (!jn[0]) begin
				rd(chA(`PWMT_GRP_COUNT, 0), rdVal);
				chk("counter in range", {31'h0, rdVal < 32'(2 * per[0])}, 32'h0000_0001);
			end
			$display("round %0d done join %0h pcm %0d", r, jn, pcm);
		end
		// stopped channels rest at their inactive level, seen through the status word
		wr(`PWMT_OFS_ENABLE, 32'h0000_0000);
		repeat (2) @(posedge clk_sys);
		rd(`PWMT_OFS_STATUS, rdVal);
		chk("status idle", rdVal, {24'h00_0000, ~pol});
		@(posedge clk_sys);
		#1;
		chk("read data cleared", regRdData, 32'h0000_0000);
		$display("status test done");
		test_done();
	end
endmodule // pwmt_timer_tb
